// [cbg_balance_ctrl.sv]
// Cell balance decision, fault and on/off timing logic with its registers
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Maximum differential threshold is 12 bits: low byte at 0x22, nibble at 0x23.
// - Balance cell when its excess over lowest cell is above min, not above max.
// - No balancing for a cell below low limit or above high limit.
// - Excess above maximum disables that cell, sets cell fault, disables the pack.
// - Raising the cell differential fault starts an open-wire test.
// - Differential code maps to volts as code times 14.4 over 12285.
// - On-time is 10-bit count at 0x24 and 0x25[1:0], unit at 0x25[3:2].
// - On-time unit: 00 us, 01 ms, 10 s, 11 min.
// - Outputs stay on for on-time count times on-time unit each cycle.
// - Off-time is 10-bit count at 0x26 and 0x27[1:0], unit at 0x27[3:2].
// - Off-time unit uses the same mapping as the on-time unit.
// - After each on period outputs stay off for off count times unit.
// - Cold threshold is 12 bits: low byte at 0x28, nibble at 0x29.
// - Set cold fault when either thermistor voltage exceeds the cold threshold.
// - Cold fault stops device balancing unless host balance control is set.
// - Clear cold fault when both thermistors fall below recovery; balancing resumes.
module cbg_balance_ctrl (
  input  wire logic                                         core_clk_in,
  input  wire logic                                         arst_n_in,
  input  wire logic                                         ce_in,
  input  wire logic [7:0]                                   reg_addr_in,
  input  wire logic [7:0]                                   reg_wdata_in,
  input  wire logic                                         reg_wr_in,
  input  wire logic                                         reg_rd_in,
  output logic      [7:0]                                   reg_rdata_out,
  input  wire logic                                         scan_done_in,
  input  wire logic [cbg_pkg::NUM_CELLS*cbg_pkg::VOLT_W-1:0] cell_volt_in,
  input  wire logic [cbg_pkg::NUM_THERM*cbg_pkg::VOLT_W-1:0] therm_volt_in,
  input  wire logic [cbg_pkg::VOLT_W-1:0]                   min_diff_threshold_in,
  input  wire logic [cbg_pkg::VOLT_W-1:0]                   balance_low_voltage_limit_in,
  input  wire logic [cbg_pkg::VOLT_W-1:0]                   balance_high_voltage_limit_in,
  input  wire logic [cbg_pkg::VOLT_W-1:0]                   cold_recovery_threshold_in,
  input  wire logic                                         host_balance_control_in,
  output logic      [cbg_pkg::NUM_CELLS-1:0]                balance_outputs_out,
  output logic                                              cell_diff_fault_out,
  output logic                                              pack_disable_out,
  output logic                                              open_wire_start_out,
  output logic                                              cold_fault_out
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [7:0] max_diff_low_reg;
  logic [3:0] max_diff_high_reg;
  logic [7:0] on_time_low_reg;
  logic [3:0] on_time_high_reg;
  logic [7:0] off_time_low_reg;
  logic [3:0] off_time_high_reg;
  logic [7:0] cold_limit_low_reg;
  logic [3:0] cold_limit_high_reg;

  logic [cbg_pkg::VOLT_W-1:0]  max_diff_threshold;
  logic [cbg_pkg::VOLT_W-1:0]  cold_threshold;
  logic [cbg_pkg::COUNT_W-1:0] on_time_count;
  logic [1:0]                  on_time_unit;
  logic [cbg_pkg::COUNT_W-1:0] off_time_count;
  logic [1:0]                  off_time_unit;

  assign max_diff_threshold = {max_diff_high_reg, max_diff_low_reg};
  assign cold_threshold     = {cold_limit_high_reg, cold_limit_low_reg};
  assign on_time_count  = {on_time_high_reg[cbg_pkg::TIME_HIGH_MSB:0], on_time_low_reg};
  assign on_time_unit   = on_time_high_reg[cbg_pkg::TIME_UNIT_MSB:cbg_pkg::TIME_UNIT_LSB];
  assign off_time_count = {off_time_high_reg[cbg_pkg::TIME_HIGH_MSB:0], off_time_low_reg};
  assign off_time_unit  = off_time_high_reg[cbg_pkg::TIME_UNIT_MSB:cbg_pkg::TIME_UNIT_LSB];

  // Upper nibble of each high byte is not stored
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      max_diff_low_reg    <= cbg_pkg::MAX_DIFF_LOW_RST;
      max_diff_high_reg   <= cbg_pkg::MAX_DIFF_HIGH_RST;
      on_time_low_reg     <= cbg_pkg::ON_TIME_LOW_RST;
      on_time_high_reg    <= cbg_pkg::ON_TIME_HIGH_RST;
      off_time_low_reg    <= cbg_pkg::OFF_TIME_LOW_RST;
      off_time_high_reg   <= cbg_pkg::OFF_TIME_HIGH_RST;
      cold_limit_low_reg  <= cbg_pkg::COLD_LIMIT_LOW_RST;
      cold_limit_high_reg <= cbg_pkg::COLD_LIMIT_HIGH_RST;
    end else if (ce_in && reg_wr_in) begin
      case (reg_addr_in)
        cbg_pkg::MAX_DIFF_LOW_ADDR:    max_diff_low_reg    <= reg_wdata_in;
        cbg_pkg::MAX_DIFF_HIGH_ADDR:   max_diff_high_reg   <= reg_wdata_in[cbg_pkg::THR_HIGH_MSB:0];
        cbg_pkg::ON_TIME_LOW_ADDR:     on_time_low_reg     <= reg_wdata_in;
        cbg_pkg::ON_TIME_HIGH_ADDR:    on_time_high_reg    <= reg_wdata_in[cbg_pkg::THR_HIGH_MSB:0];
        cbg_pkg::OFF_TIME_LOW_ADDR:    off_time_low_reg    <= reg_wdata_in;
        cbg_pkg::OFF_TIME_HIGH_ADDR:   off_time_high_reg   <= reg_wdata_in[cbg_pkg::THR_HIGH_MSB:0];
        cbg_pkg::COLD_LIMIT_LOW_ADDR:  cold_limit_low_reg  <= reg_wdata_in;
        cbg_pkg::COLD_LIMIT_HIGH_ADDR: cold_limit_high_reg <= reg_wdata_in[cbg_pkg::THR_HIGH_MSB:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Register read
  // ****************************************************************
  logic [7:0] read_mux;

  always_comb begin
    case (reg_addr_in)
      cbg_pkg::MAX_DIFF_LOW_ADDR:    read_mux = max_diff_low_reg;
      cbg_pkg::MAX_DIFF_HIGH_ADDR:   read_mux = {4'h0, max_diff_high_reg};
      cbg_pkg::ON_TIME_LOW_ADDR:     read_mux = on_time_low_reg;
      cbg_pkg::ON_TIME_HIGH_ADDR:    read_mux = {4'h0, on_time_high_reg};
      cbg_pkg::OFF_TIME_LOW_ADDR:    read_mux = off_time_low_reg;
      cbg_pkg::OFF_TIME_HIGH_ADDR:   read_mux = {4'h0, off_time_high_reg};
      cbg_pkg::COLD_LIMIT_LOW_ADDR:  read_mux = cold_limit_low_reg;
      cbg_pkg::COLD_LIMIT_HIGH_ADDR: read_mux = {4'h0, cold_limit_high_reg};
      default:                       read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (ce_in && reg_rd_in) begin
      reg_rdata_out <= read_mux;
    end
  end

  // ****************************************************************
  // Per-cell balance decision
  // ****************************************************************
  // Differential thresholds share the cell code scale, so codes compare directly
  logic [cbg_pkg::VOLT_W-1:0]    lowest_cell;
  logic [cbg_pkg::NUM_CELLS-1:0] cell_enable;
  logic [cbg_pkg::NUM_CELLS-1:0] cell_over_max;

  always_comb begin
    lowest_cell = cell_volt_in[cbg_pkg::VOLT_W-1:0];
    for (int i = 1; i < cbg_pkg::NUM_CELLS; i++) begin
      if (cell_volt_in[i*cbg_pkg::VOLT_W +: cbg_pkg::VOLT_W] < lowest_cell) begin
        lowest_cell = cell_volt_in[i*cbg_pkg::VOLT_W +: cbg_pkg::VOLT_W];
      end
    end
  end

  generate
    for (genvar g = 0; g < cbg_pkg::NUM_CELLS; g++) begin : gen_cell
      logic [cbg_pkg::VOLT_W-1:0] volt;
      logic [cbg_pkg::VOLT_W-1:0] excess;
      logic                       in_window;
      assign volt      = cell_volt_in[g*cbg_pkg::VOLT_W +: cbg_pkg::VOLT_W];
      assign excess    = volt - lowest_cell;
      assign in_window = (volt >= balance_low_voltage_limit_in) &&
                         (volt <= balance_high_voltage_limit_in);
      assign cell_over_max[g] = (excess > max_diff_threshold);
      assign cell_enable[g]   = in_window && (excess > min_diff_threshold_in) &&
                                !cell_over_max[g];
    end
  endgenerate

  logic [cbg_pkg::NUM_CELLS-1:0] balance_mask_reg;

  // Decisions refresh only on a completed scan
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      balance_mask_reg <= 8'h00;
    end else if (ce_in && scan_done_in) begin
      balance_mask_reg <= cell_enable;
    end
  end

  // ****************************************************************
  // Cell differential fault
  // ****************************************************************
  logic diff_fault_now;

  assign diff_fault_now = |cell_over_max;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cell_diff_fault_out <= 1'b0;
      pack_disable_out    <= 1'b0;
      open_wire_start_out <= 1'b0;
    end else if (ce_in) begin
      open_wire_start_out <= 1'b0;
      if (scan_done_in) begin
        cell_diff_fault_out <= diff_fault_now;
        pack_disable_out    <= diff_fault_now;
        open_wire_start_out <= diff_fault_now && !cell_diff_fault_out;
      end
    end
  end

  // ****************************************************************
  // Cold fault
  // ****************************************************************
  logic therm_any_hot;
  logic therm_all_rec;

  always_comb begin
    therm_any_hot = 1'b0;
    therm_all_rec = 1'b1;
    for (int t = 0; t < cbg_pkg::NUM_THERM; t++) begin
      if (therm_volt_in[t*cbg_pkg::VOLT_W +: cbg_pkg::VOLT_W] > cold_threshold) begin
        therm_any_hot = 1'b1;
      end
      if (therm_volt_in[t*cbg_pkg::VOLT_W +: cbg_pkg::VOLT_W] >= cold_recovery_threshold_in) begin
        therm_all_rec = 1'b0;
      end
    end
  end

  // Setting takes priority over recovery on the same scan
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cold_fault_out <= 1'b0;
    end else if (ce_in && scan_done_in) begin
      if (therm_any_hot) begin
        cold_fault_out <= 1'b1;
      end else if (therm_all_rec) begin
        cold_fault_out <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // On/off cycle sequencer
  // ****************************************************************
  typedef enum logic [1:0] {
    CBG_IDLE,
    CBG_ON,
    CBG_OFF
  } cbg_phase_t;

  cbg_phase_t                  phase_reg;
  cbg_phase_t                  phase_next;
  logic                        permit;
  logic                        timer_start;
  logic                        timer_done;
  logic [cbg_pkg::COUNT_W-1:0] timer_count;
  logic [1:0]                  timer_unit;

  assign permit = !cell_diff_fault_out &&
                  !(cold_fault_out && !host_balance_control_in);

  always_comb begin
    phase_next  = phase_reg;
    timer_start = 1'b0;
    case (phase_reg)
      CBG_IDLE: begin
        if (permit) begin
          phase_next  = CBG_ON;
          timer_start = 1'b1;
        end
      end
      CBG_ON: begin
        if (!permit) begin
          phase_next = CBG_IDLE;
        end else if (timer_done) begin
          phase_next  = CBG_OFF;
          timer_start = 1'b1;
        end
      end
      CBG_OFF: begin
        if (!permit) begin
          phase_next = CBG_IDLE;
        end else if (timer_done) begin
          phase_next  = CBG_ON;
          timer_start = 1'b1;
        end
      end
      default: begin
        phase_next = CBG_IDLE;
      end
    endcase
  end

  assign timer_count = (phase_next == CBG_ON) ? on_time_count : off_time_count;
  assign timer_unit  = (phase_next == CBG_ON) ? on_time_unit : off_time_unit;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_reg <= CBG_IDLE;
    end else if (ce_in) begin
      phase_reg <= phase_next;
    end
  end

  cbg_period_timer u_timer (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .ce_in       (ce_in),
    .start_in    (timer_start),
    .count_in    (timer_count),
    .unit_in     (timer_unit),
    .done_out    (timer_done)
  );

  // ****************************************************************
  // Balance outputs
  // ****************************************************************
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      balance_outputs_out <= 8'h00;
    end else if (ce_in) begin
      balance_outputs_out <= (phase_next == CBG_ON) ? balance_mask_reg : 8'h00;
    end
  end

endmodule
`default_nettype wire

// [cbg_pkg.sv]
// Shared constants for the cell balance gating and timing block
package cbg_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] MAX_DIFF_LOW_ADDR    = 8'h22;
  localparam logic [7:0] MAX_DIFF_HIGH_ADDR   = 8'h23;
  localparam logic [7:0] ON_TIME_LOW_ADDR     = 8'h24;
  localparam logic [7:0] ON_TIME_HIGH_ADDR    = 8'h25;
  localparam logic [7:0] OFF_TIME_LOW_ADDR    = 8'h26;
  localparam logic [7:0] OFF_TIME_HIGH_ADDR   = 8'h27;
  localparam logic [7:0] COLD_LIMIT_LOW_ADDR  = 8'h28;
  localparam logic [7:0] COLD_LIMIT_HIGH_ADDR = 8'h29;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] MAX_DIFF_LOW_RST     = 8'hab;
  localparam logic [3:0] MAX_DIFF_HIGH_RST    = 4'h1;
  localparam logic [7:0] ON_TIME_LOW_RST      = 8'h02;
  localparam logic [3:0] ON_TIME_HIGH_RST     = 4'h8;
  localparam logic [7:0] OFF_TIME_LOW_RST     = 8'h02;
  localparam logic [3:0] OFF_TIME_HIGH_RST    = 4'h8;
  localparam logic [7:0] COLD_LIMIT_LOW_RST   = 8'hf2;
  localparam logic [3:0] COLD_LIMIT_HIGH_RST  = 4'hb;

  // ****************************************************************
  // Field layout of the high bytes
  // ****************************************************************
  localparam int THR_HIGH_MSB   = 3;
  localparam int TIME_HIGH_MSB  = 1;
  localparam int TIME_UNIT_MSB  = 3;
  localparam int TIME_UNIT_LSB  = 2;

  // ****************************************************************
  // Sizes and unit encodings
  // ****************************************************************
  localparam int NUM_CELLS = 8;
  localparam int NUM_THERM = 2;
  localparam int VOLT_W    = 12;
  localparam int COUNT_W   = 10;

  typedef enum logic [1:0] {
    CBG_UNIT_US  = 2'h0,
    CBG_UNIT_MS  = 2'h1,
    CBG_UNIT_SEC = 2'h2,
    CBG_UNIT_MIN = 2'h3
  } cbg_unit_t;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int US_PS         = 1000000;
  localparam int US_PER_MS     = 1000;
  localparam int MS_PER_SEC    = 1000;
  localparam int SEC_PER_MIN   = 60;
  localparam int CYC_PER_US    = US_PS / CLK_PERIOD_PS;

  localparam logic [7:0] CYC_US_LAST  = 8'(CYC_PER_US - 1);
  localparam logic [9:0] US_MS_LAST   = 10'(US_PER_MS - 1);
  localparam logic [9:0] MS_SEC_LAST  = 10'(MS_PER_SEC - 1);
  localparam logic [5:0] SEC_MIN_LAST = 6'(SEC_PER_MIN - 1);

endpackage

// [cbg_period_timer.sv]
// Period timer counting a 10-bit number of selectable time units
`timescale 1ns/1ps
`default_nettype none

module cbg_period_timer (
  input  wire logic                       core_clk_in,
  input  wire logic                       arst_n_in,
  input  wire logic                       ce_in,
  input  wire logic                       start_in,
  input  wire logic [cbg_pkg::COUNT_W-1:0] count_in,
  input  wire logic [1:0]                 unit_in,
  output logic                            done_out
);

  // ****************************************************************
  // Base tick chain
  // ****************************************************************
  logic [7:0]                  cyc_reg;
  logic [9:0]                  us_reg;
  logic [9:0]                  ms_reg;
  logic [5:0]                  sec_reg;
  logic [cbg_pkg::COUNT_W-1:0] units_reg;
  logic                        running_reg;
  logic                        tick_us;
  logic                        tick_ms;
  logic                        tick_sec;
  logic                        tick_min;
  logic                        unit_tick;

  assign tick_us  = (cyc_reg == cbg_pkg::CYC_US_LAST);
  assign tick_ms  = tick_us && (us_reg == cbg_pkg::US_MS_LAST);
  assign tick_sec = tick_ms && (ms_reg == cbg_pkg::MS_SEC_LAST);
  assign tick_min = tick_sec && (sec_reg == cbg_pkg::SEC_MIN_LAST);

  // Unit decode, same mapping for on and off periods
  always_comb begin
    case (cbg_pkg::cbg_unit_t'(unit_in))
      cbg_pkg::CBG_UNIT_US:  unit_tick = tick_us;
      cbg_pkg::CBG_UNIT_MS:  unit_tick = tick_ms;
      cbg_pkg::CBG_UNIT_SEC: unit_tick = tick_sec;
      cbg_pkg::CBG_UNIT_MIN: unit_tick = tick_min;
      default:               unit_tick = 1'b0;
    endcase
  end

  // Prescalers restart with each period so the first unit is whole
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cyc_reg <= 8'h00;
      us_reg  <= 10'h000;
      ms_reg  <= 10'h000;
      sec_reg <= 6'h00;
    end else if (ce_in) begin
      if (start_in || !running_reg) begin
        cyc_reg <= 8'h00;
        us_reg  <= 10'h000;
        ms_reg  <= 10'h000;
        sec_reg <= 6'h00;
      end else begin
        cyc_reg <= tick_us ? 8'h00 : cyc_reg + 8'h01;
        if (tick_us) begin
          us_reg <= tick_ms ? 10'h000 : us_reg + 10'h001;
        end
        if (tick_ms) begin
          ms_reg <= tick_sec ? 10'h000 : ms_reg + 10'h001;
        end
        if (tick_sec) begin
          sec_reg <= tick_min ? 6'h00 : sec_reg + 6'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Unit counter, count times unit
  // ****************************************************************
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      units_reg   <= 10'h000;
      running_reg <= 1'b0;
      done_out    <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (start_in) begin
        units_reg   <= 10'h000;
        running_reg <= 1'b1;
      end else if (running_reg) begin
        if (units_reg == count_in) begin
          running_reg <= 1'b0;
          done_out    <= 1'b1;
        end else if (unit_tick) begin
          units_reg <= units_reg + 10'h001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [cbg_pack_model.sv]
// Model of the pack cells and thermistors that deliver one scan on request
`timescale 1ns/1ps
`default_nettype none
module cbg_pack_model (
  input  wire logic        clk_in,
  input  wire logic        req_in,
  input  wire logic [11:0] c3_in,
  input  wire logic [11:0] c5_in,
  input  wire logic [11:0] therm_in,
  output logic             scan_done_out,
  output logic [95:0]      cell_volt_out,
  output logic [23:0]      therm_volt_out
);
  logic        sd = 1'b0;
  logic [95:0] cells;
  // Codes step by 14.4 over 12285 volts
  always_comb begin
    cells = {8{12'h3e8}};
    cells[47:36] = c3_in;
    cells[71:60] = c5_in;
  end
  always @(posedge clk_in) begin
    sd <= req_in;
  end
  // Values are scrambled outside the scan pulse
  assign scan_done_out  = sd;
  assign cell_volt_out  = sd ? cells : ~cells;
  assign therm_volt_out = sd ? {2{therm_in}} : ~{2{therm_in}};
endmodule
`default_nettype wire

// [cbg_balance_monitor.sv]
// Port checker for the cell balance block
`timescale 1ns/1ps
`default_nettype none
module cbg_balance_monitor (
  input wire logic       core_clk_in,
  input wire logic       arst_n_in,
  input wire logic       ce_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       scan_done_in,
  input wire logic       host_balance_control_in,
  input wire logic [7:0] balance_outputs_out,
  input wire logic       cell_diff_fault_out,
  input wire logic       pack_disable_out,
  input wire logic       open_wire_start_out,
  input wire logic       cold_fault_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_scan;
    scan_done_in && ce_in;
  endsequence
  sequence s_read;
    reg_rd_in && ce_in;
  endsequence
  chk_pack_equal: assert property (pack_disable_out == cell_diff_fault_out)
    else $error("Pack disable differs from cell fault");
  chk_owire_rise: assert property (open_wire_start_out == $rose(cell_diff_fault_out))
    else $error("Open wire start not tied to fault rise");
  chk_owire_pulse: assert property (open_wire_start_out |=> !open_wire_start_out)
    else $error("Open wire start longer than one cycle");
  chk_fault_gate: assert property (cell_diff_fault_out |=> balance_outputs_out == 8'h00)
    else $error("Balancing during cell fault");
  chk_cold_gate: assert property (cold_fault_out && !host_balance_control_in |=> balance_outputs_out == 8'h00)
    else $error("Balancing during cold fault");
  chk_scan_hold: assert property (!(scan_done_in && ce_in) |=> $stable(cell_diff_fault_out) && $stable(cold_fault_out))
    else $error("Fault changed without a scan");
  chk_rd_unmapped: assert property (s_read ##0 !(reg_addr_in inside {[8'h22:8'h29]}) |=> reg_rdata_out == 8'h00)
    else $error("Unmapped read not zero");
  chk_rd_nibble: assert property (s_read ##0 reg_addr_in[0] && reg_addr_in inside {[8'h23:8'h29]}
    |=> reg_rdata_out[7:4] == 4'h0)
    else $error("Reserved nibble not zero");
endmodule
bind cbg_balance_ctrl cbg_balance_monitor i_mon (.core_clk_in, .arst_n_in, .ce_in, .reg_addr_in, .reg_rd_in,
  .reg_rdata_out, .scan_done_in, .host_balance_control_in, .balance_outputs_out, .cell_diff_fault_out,
  .pack_disable_out, .open_wire_start_out, .cold_fault_out);
`default_nettype wire

// [cbg_balance_ctrl_tb.sv]
// Self-checking bench for the cell balance block
`timescale 1ns/1ps
`default_nettype none
module cbg_balance_ctrl_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        req = 1'b0;
  logic        host = 1'b0;
  logic [11:0] c3 = 12'h3e8;
  logic [11:0] c5 = 12'h3e8;
  logic [11:0] tv = 12'h000;
  logic [11:0] hi = 12'hfff;
  logic [11:0] lo = 12'h000;
  logic        ce = 1'b1;
  logic [7:0]  rdata, bal, v;
  logic [95:0] cells;
  logic [23:0] therms;
  logic        scan, cf, pd, ow, cold;
  int          error_cnt = 0;
  int          checks_done = 0;
  always #2.5 clk = ~clk;
  cbg_pack_model i_pack (.clk_in(clk), .req_in(req), .c3_in(c3), .c5_in(c5), .therm_in(tv),
    .scan_done_out(scan), .cell_volt_out(cells), .therm_volt_out(therms));
  // Recovery threshold held below the cold threshold
  cbg_balance_ctrl i_dut (.core_clk_in(clk), .arst_n_in(rst_n), .ce_in(ce), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .scan_done_in(scan),
    .cell_volt_in(cells), .therm_volt_in(therms), .min_diff_threshold_in(12'd10),
    .balance_low_voltage_limit_in(lo), .balance_high_voltage_limit_in(hi),
    .cold_recovery_threshold_in(12'h900), .host_balance_control_in(host),
    .balance_outputs_out(bal), .cell_diff_fault_out(cf), .pack_disable_out(pd),
    .open_wire_start_out(ow), .cold_fault_out(cold));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input string n, input logic [11:0] e, input logic [11:0] s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmp_rng(input string n, input int lo, input int hi_v, input int s);
    checks_done++;
    if (s < lo || s > hi_v) begin
      error_cnt++;
      $display("ERROR %s expected %0d to %0d seen %0d", n, lo, hi_v, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    step(1);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    step(1);
    addr = a;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    d = rdata;
  endtask
  task automatic scan_at(input logic [11:0] t, input logic [11:0] a = 12'd1427,
                         input logic [11:0] b = 12'd1000, input logic [11:0] h = 12'hfff);
    step(1);
    {tv, c3, c5, hi} = {t, a, b, h};
    req = 1'b1;
    step(1);
    req = 1'b0;
    step(1);
  endtask
  task automatic count_bal(input logic on, output int n);
    n = 0;
    while (((bal !== 8'h00) == on) && n < 5000) begin
      step(1);
      n++;
    end
  endtask
  task automatic t_reset();
    logic [7:0] rv [8] = '{8'hab, 8'h01, 8'h02, 8'h08, 8'h02, 8'h08, 8'hf2, 8'h0b};
    for (int i = 0; i < 8; i++) begin
      rd_reg(8'h22 + 8'(i), v);
      cmp("reset_value", 12'(rv[i]), 12'(v));
    end
    $display("Test reset done");
  endtask
  task automatic t_diff();
    scan_at(12'h000, 12'd1050, 12'd1100, 12'd1080);
    step(1);
    cmp("balance_mask", 12'h008, 12'(bal));
    lo = 12'd1051;
    scan_at(12'h000, 12'd1050, 12'd1100, 12'd1080);
    step(1);
    cmp("balance_mask", 12'h000, 12'(bal));
    lo = 12'h000;
    wr_reg(8'h24, 8'h03);
    wr_reg(8'h25, 8'h00);
    wr_reg(8'h26, 8'h02);
    wr_reg(8'h27, 8'h00);
    scan_at(12'h000, 12'd1428, 12'd1050);
    cmp("cell_diff_fault", 12'h001, 12'(cf));
    cmp("pack_disable", 12'h001, 12'(pd));
    cmp("open_wire_start", 12'h001, 12'(ow));
    step(1);
    cmp("balance_outputs", 12'h000, 12'(bal));
    scan_at(12'h000);
    cmp("cell_diff_fault", 12'h000, 12'(cf));
    step(2);
    cmp("balance_outputs", 12'h008, 12'(bal));
    $display("Test differential done");
  endtask
  task automatic t_timing();
    int n;
    count_bal(1'b1, n);
    count_bal(1'b0, n);
    cmp_rng("off_time", 399, 405, n);
    count_bal(1'b1, n);
    cmp_rng("on_time", 599, 605, n);
    $display("Test timing done");
  endtask
  task automatic t_cold();
    scan_at(12'hbf2);
    cmp("cold_fault", 12'h000, 12'(cold));
    scan_at(12'hbf3);
    cmp("cold_fault", 12'h001, 12'(cold));
    step(1);
    cmp("balance_outputs", 12'h000, 12'(bal));
    host = 1'b1;
    step(2);
    cmp("balance_outputs", 12'h008, 12'(bal));
    host = 1'b0;
    step(1);
    cmp("balance_outputs", 12'h000, 12'(bal));
    scan_at(12'ha00);
    cmp("cold_fault", 12'h001, 12'(cold));
    scan_at(12'h8ff);
    cmp("cold_fault", 12'h000, 12'(cold));
    step(2);
    cmp("balance_outputs", 12'h008, 12'(bal));
    $display("Test cold done");
  endtask
  task automatic t_regs();
    wr_reg(8'h25, 8'h0f);
    rd_reg(8'h25, v);
    cmp("high_nibble", 12'h00f, 12'(v));
    wr_reg(8'h30, 8'h5a);
    rd_reg(8'h30, v);
    cmp("unmapped", 12'h000, 12'(v));
    wr_reg(8'h22, 8'h5a);
    rd_reg(8'h22, v);
    cmp("max_diff_low", 12'h05a, 12'(v));
    ce = 1'b0;
    wr_reg(8'h22, 8'h33);
    ce = 1'b1;
    rd_reg(8'h22, v);
    cmp("ce_frozen", 12'h05a, 12'(v));
    $display("Test registers done");
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_diff();
    t_timing();
    t_cold();
    t_regs();
    print_verdict();
  end
endmodule
`default_nettype wire
